// *** src/scsp_top.sv ***
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "scsp_regs.svh"

// Overview of operation
// - partition/link word shifted out when reading
// - jabber/buffer word shifted out when reading
// - enable word driven on its pin reading
// - far side shifts words in, port order
// - disable word driven on its pin reading
// - isolation status shifted out, port 0 first
// - latch strobe output reading, input writing
// - write direction resets read sequencer at once
// - bit 0 first, strobe after bit 15
// - outputs change on falling shift_clock edge
// - bypass select high: per-port scrambler enables
// - bypass select low: all scramblers bypassed
// - chip reset clears all logic but the enable word, which resets to all ones
// - write direction forces management data low
// - command, status, port-reset unreachable serially
// - isolation and disable words map to registers
module scsp_top
  import scsp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // serial pins
  input wire logic shift_clock,
  input wire logic read_write_select,
  input wire logic scrambler_bypass_select,
  output logic partition_link_status_out,
  output logic jabber_buffer_status_out,
  output logic port_cutoff_status_out,
  input wire logic port_scrambler_enable_in,
  output logic port_scrambler_enable_out,
  output logic port_scrambler_enable_oe,
  input wire logic partition_detach_disable_in,
  output logic partition_detach_disable_out,
  output logic partition_detach_disable_oe,
  input wire logic frame_latch_strobe_in,
  output logic frame_latch_strobe_out,
  output logic frame_latch_strobe_oe,
  // status from the repeater core
  input wire scsp_status_t port_status,
  // control to the repeater core
  output logic [7:0] port_enable,
  output logic [7:0] scrambler_active,
  output logic [7:0] partition_disable,
  output logic [7:0] isolation_disable,
  output logic mgmt_data_force_low,
  // management register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  scsp_pins_t pins_raw;
  scsp_pins_t pins;
  logic [5:0] pins_sync;

  assign pins_raw = '{
    shift_clock: shift_clock,
    read_write_select: read_write_select,
    strobe: frame_latch_strobe_in,
    enable_bit: port_scrambler_enable_in,
    disable_bit: partition_detach_disable_in,
    scrambler_bypass_select: scrambler_bypass_select
  };

  scsp_sync #(
    .WIDTH(6)
  ) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign pins = scsp_pins_t'(pins_sync);

  // ****************************************
  // shift clock edge detection
  // ****************************************
  logic shift_clock_prev;
  logic shift_rise;
  logic shift_fall;
  logic read_mode;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_clock_prev <= 1'b0;
    end else begin
      shift_clock_prev <= pins.shift_clock;
    end
  end

  assign shift_rise = pins.shift_clock & ~shift_clock_prev;
  assign shift_fall = ~pins.shift_clock & shift_clock_prev;
  assign read_mode = pins.read_write_select;

  // ****************************************
  // control registers
  // ****************************************
  scsp_word_t enable_word;
  scsp_word_t disable_word;
  scsp_word_t next_enable_word;
  scsp_word_t next_disable_word;
  scsp_word_t enable_shift;
  scsp_word_t disable_shift;
  logic word_apply;

  always_comb begin
    next_enable_word = enable_word;
    next_disable_word = disable_word;
    // management writes lose to the serial pins
    if (reg_write && read_mode) begin
      // only the shared words are decoded
      case (reg_addr)
        `SCSP_ADDR_ENABLE: begin
          next_enable_word = reg_wdata;
        end
        `SCSP_ADDR_DISABLE: begin
          next_disable_word = reg_wdata;
        end
        default: begin
        end
      endcase
    end
    if (word_apply) begin
      next_enable_word = enable_shift;
      next_disable_word = disable_shift;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enable_word <= `SCSP_ENABLE_RESET;
      disable_word <= `SCSP_DISABLE_RESET;
    end else begin
      enable_word <= next_enable_word;
      disable_word <= next_disable_word;
    end
  end

  // ****************************************
  // control outputs
  // ****************************************
  // first field port enable, second scrambler enable
  assign port_enable = enable_word.first;
  assign scrambler_active = pins.scrambler_bypass_select ? enable_word.second : 8'h00;
  // disable word feeds partition and isolation disables
  assign partition_disable = disable_word.first;
  assign isolation_disable = disable_word.second;
  // management data held low in write direction
  assign mgmt_data_force_low = ~read_mode;

  // ****************************************
  // management read port
  // ****************************************
  logic [15:0] next_reg_rdata;

  always_comb begin
    next_reg_rdata = `SCSP_RDATA_RESET;
    if (reg_read) begin
      case (reg_addr)
        `SCSP_ADDR_ENABLE: begin
          next_reg_rdata = enable_word;
        end
        `SCSP_ADDR_PART_LINK: begin
          next_reg_rdata = port_status.part_link;
        end
        `SCSP_ADDR_JAB_BUF: begin
          next_reg_rdata = port_status.jab_buf;
        end
        `SCSP_ADDR_ISOLATION: begin
          next_reg_rdata = {8'h00, port_status.isolation};
        end
        `SCSP_ADDR_DISABLE: begin
          next_reg_rdata = disable_word;
        end
        default: begin
          next_reg_rdata = `SCSP_RDATA_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `SCSP_RDATA_RESET;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // ****************************************
  // serial read sequencer
  // ****************************************
  scsp_rd_state_t rd_state;
  scsp_rd_state_t next_rd_state;
  logic [4:0] rd_count;
  logic [4:0] next_rd_count;
  scsp_word_t snap_part_link;
  scsp_word_t snap_jab_buf;
  scsp_word_t snap_enable;
  scsp_word_t snap_disable;
  scsp_word_t snap_isolation;
  scsp_word_t next_snap_part_link;
  scsp_word_t next_snap_jab_buf;
  scsp_word_t next_snap_enable;
  scsp_word_t next_snap_disable;
  scsp_word_t next_snap_isolation;
  scsp_serial_t ser_out;
  scsp_serial_t next_ser_out;
  logic strobe_out;
  logic next_strobe_out;
  logic [3:0] bit_sel;

  assign bit_sel = rd_count[3:0];

  always_comb begin
    next_rd_state = rd_state;
    next_rd_count = rd_count;
    next_snap_part_link = snap_part_link;
    next_snap_jab_buf = snap_jab_buf;
    next_snap_enable = snap_enable;
    next_snap_disable = snap_disable;
    next_snap_isolation = snap_isolation;
    next_ser_out = ser_out;
    next_strobe_out = strobe_out;
    // write direction stops the read sequencer at once
    if (!read_mode) begin
      next_rd_state = rd_idle;
      next_rd_count = `SCSP_FIRST_BIT;
      next_ser_out = '0;
      next_strobe_out = 1'b0;
    end else if (shift_fall) begin
      // all serial outputs move on the falling edge
      case (rd_state)
        rd_idle, rd_latch: begin
          // new frame from bit 0 after each strobe
          next_snap_part_link = port_status.part_link;
          next_snap_jab_buf = port_status.jab_buf;
          next_snap_enable = enable_word;
          next_snap_disable = disable_word;
          next_snap_isolation = {8'h00, port_status.isolation};
          // bit 0 ready for the first rising edge
          next_ser_out = '{
            part_link: port_status.part_link[0],
            jab_buf: port_status.jab_buf[0],
            enable_bit: enable_word[0],
            disable_bit: disable_word[0],
            isolation: port_status.isolation[0]
          };
          next_strobe_out = 1'b0;
          next_rd_count = `SCSP_FIRST_BIT + `SCSP_BIT_STEP;
          next_rd_state = rd_shift;
        end
        rd_shift: begin
          if (rd_count == `SCSP_LATCH_SLOT) begin
            next_strobe_out = 1'b1;
            next_ser_out = '0;
            next_rd_count = `SCSP_FIRST_BIT;
            next_rd_state = rd_latch;
          end else begin
            // bit index walks port 0..7 of each field
            next_ser_out = '{
              part_link: snap_part_link[bit_sel],
              jab_buf: snap_jab_buf[bit_sel],
              enable_bit: snap_enable[bit_sel],
              disable_bit: snap_disable[bit_sel],
              isolation: snap_isolation[bit_sel]
            };
            next_rd_count = rd_count + `SCSP_BIT_STEP;
          end
        end
        default: begin
          next_rd_state = rd_idle;
          next_rd_count = `SCSP_FIRST_BIT;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_state <= rd_idle;
      rd_count <= `SCSP_FIRST_BIT;
      snap_part_link <= '0;
      snap_jab_buf <= '0;
      snap_enable <= '0;
      snap_disable <= '0;
      snap_isolation <= '0;
      ser_out <= '0;
      strobe_out <= 1'b0;
    end else begin
      rd_state <= next_rd_state;
      rd_count <= next_rd_count;
      snap_part_link <= next_snap_part_link;
      snap_jab_buf <= next_snap_jab_buf;
      snap_enable <= next_snap_enable;
      snap_disable <= next_snap_disable;
      snap_isolation <= next_snap_isolation;
      ser_out <= next_ser_out;
      strobe_out <= next_strobe_out;
    end
  end

  // ****************************************
  // serial pin drivers
  // ****************************************
  assign partition_link_status_out = ser_out.part_link;
  assign jabber_buffer_status_out = ser_out.jab_buf;
  assign port_cutoff_status_out = ser_out.isolation;
  assign port_scrambler_enable_out = ser_out.enable_bit;
  assign partition_detach_disable_out = ser_out.disable_bit;
  assign frame_latch_strobe_out = strobe_out;
  // two-way data pins driven only when reading
  assign port_scrambler_enable_oe = read_mode;
  assign partition_detach_disable_oe = read_mode;
  // strobe is an output only in read direction
  assign frame_latch_strobe_oe = read_mode;

  // ****************************************
  // serial write receiver
  // ****************************************
  scsp_wr_state_t wr_state;
  scsp_wr_state_t next_wr_state;
  logic [4:0] wr_count;
  logic [4:0] next_wr_count;
  scsp_word_t next_enable_shift;
  scsp_word_t next_disable_shift;
  logic next_word_apply;
  logic [3:0] wr_sel;

  assign wr_sel = wr_count[3:0];

  always_comb begin
    next_wr_state = wr_state;
    next_wr_count = wr_count;
    next_enable_shift = enable_shift;
    next_disable_shift = disable_shift;
    next_word_apply = 1'b0;
    if (read_mode) begin
      next_wr_state = wr_idle;
      next_wr_count = `SCSP_FIRST_BIT;
    end else begin
      case (wr_state)
        wr_idle: begin
          // strobe taken from the far side in write direction
          if (pins.strobe) begin
            next_wr_count = `SCSP_FIRST_BIT;
            next_wr_state = wr_shift;
          end
        end
        wr_shift: begin
          // one bit of each word per rising edge, port order
          if (shift_rise) begin
            next_enable_shift[wr_sel] = pins.enable_bit;
            next_disable_shift[wr_sel] = pins.disable_bit;
            next_wr_count = wr_count + `SCSP_BIT_STEP;
            // apply once bit 15 is in
            if (wr_count == `SCSP_LAST_BIT) begin
              next_word_apply = 1'b1;
              next_wr_state = wr_wait;
            end
          end
        end
        wr_wait: begin
          // extra edges ignored until the strobe falls
          if (!pins.strobe) begin
            next_wr_state = wr_idle;
          end
        end
        default: begin
          next_wr_state = wr_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_state <= wr_idle;
      wr_count <= `SCSP_FIRST_BIT;
      enable_shift <= '0;
      disable_shift <= '0;
      word_apply <= 1'b0;
    end else begin
      wr_state <= next_wr_state;
      wr_count <= next_wr_count;
      enable_shift <= next_enable_shift;
      disable_shift <= next_disable_shift;
      word_apply <= next_word_apply;
    end
  end

endmodule

// *** common/scsp_regs.svh ***
`ifndef SCSP_REGS_SVH
`define SCSP_REGS_SVH

// ****************************************
// register indices on the management port
// ****************************************
`define SCSP_ADDR_ENABLE 5'h11
`define SCSP_ADDR_PART_LINK 5'h12
`define SCSP_ADDR_JAB_BUF 5'h13
`define SCSP_ADDR_ISOLATION 5'h14
`define SCSP_ADDR_DISABLE 5'h15

// ****************************************
// reset values
// ****************************************
`define SCSP_ENABLE_RESET 16'hFFFF
`define SCSP_DISABLE_RESET 16'h0000
`define SCSP_RDATA_RESET 16'h0000

// ****************************************
// serial frame timing, in shift_clock edges
// ****************************************
`define SCSP_FIRST_BIT 5'h00
`define SCSP_LAST_BIT 5'h0F
`define SCSP_LATCH_SLOT 5'h10
`define SCSP_BIT_STEP 5'h01

// highest shift_clock rate the far side should use, in kHz
`define SCSP_SHIFT_MAX_KHZ 12500

`endif

// *** common/scsp_pkg.sv ***
package scsp_pkg;

  // one 16-bit serial word: low byte first field, high byte second field
  typedef struct packed {
    logic [7:0] second;
    logic [7:0] first;
  } scsp_word_t;

  // per-port status presented by the repeater core
  typedef struct packed {
    scsp_word_t part_link;
    scsp_word_t jab_buf;
    logic [7:0] isolation;
  } scsp_status_t;

  // pins sampled from outside the clock domain
  typedef struct packed {
    logic shift_clock;
    logic read_write_select;
    logic strobe;
    logic enable_bit;
    logic disable_bit;
    logic scrambler_bypass_select;
  } scsp_pins_t;

  // serial data outputs of a read frame
  typedef struct packed {
    logic part_link;
    logic jab_buf;
    logic enable_bit;
    logic disable_bit;
    logic isolation;
  } scsp_serial_t;

  typedef enum logic [1:0] {
    rd_idle,
    rd_shift,
    rd_latch
  } scsp_rd_state_t;

  typedef enum logic [1:0] {
    wr_idle,
    wr_shift,
    wr_wait
  } scsp_wr_state_t;

endpackage

// *** src/scsp_sync.sv ***
`timescale 1ns/10ps

module scsp_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// *** verif/scsp_properties.sv ***
`timescale 1ns/10ps
module scsp_checker
  import scsp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // serial pins
  input wire logic shift_clock,
  input wire logic read_write_select,
  input wire logic scrambler_bypass_select,
  input wire logic partition_link_status_out,
  input wire logic jabber_buffer_status_out,
  input wire logic port_cutoff_status_out,
  input wire logic port_scrambler_enable_oe,
  input wire logic partition_detach_disable_oe,
  input wire logic frame_latch_strobe_out,
  input wire logic frame_latch_strobe_oe,
  // core and register port
  input wire scsp_status_t port_status,
  input wire logic [7:0] port_enable,
  input wire logic [7:0] scrambler_active,
  input wire logic [7:0] partition_disable,
  input wire logic [7:0] isolation_disable,
  input wire logic mgmt_data_force_low,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata
);
  // *******
  // properties
  // *******
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_oe_read: assert property (
    read_write_select [*5] |-> frame_latch_strobe_oe && port_scrambler_enable_oe
      && partition_detach_disable_oe) else $error("read direction without drive");
  a_force_low: assert property (
    !read_write_select [*5] |-> mgmt_data_force_low && !frame_latch_strobe_oe)
    else $error("write direction not forcing management low");
  a_write_quiet: assert property (
    !read_write_select [*5] |-> !partition_link_status_out && !jabber_buffer_status_out
      && !port_cutoff_status_out && !frame_latch_strobe_out) else $error("read not reset");
  a_strobe_data: assert property (
    frame_latch_strobe_out |-> !partition_link_status_out && !jabber_buffer_status_out)
    else $error("data during strobe slot");
  a_strobe_width: assert property (
    $rose(frame_latch_strobe_out) |=> frame_latch_strobe_out [*5])
    else $error("strobe shorter than a shift period");
  a_change_fall: assert property (
    $changed({partition_link_status_out, jabber_buffer_status_out, port_cutoff_status_out,
      frame_latch_strobe_out}) |-> !shift_clock) else $error("output changed while high");
  a_bypass_off: assert property (
    !scrambler_bypass_select [*5] |-> scrambler_active == 8'h00)
    else $error("scrambler active while bypassed");
  a_iso_read: assert property (
    reg_read && reg_addr == 5'h14 |=> reg_rdata == {8'h00, $past(port_status.isolation)})
    else $error("isolation readback wrong");
  a_status_read: assert property (
    reg_read && reg_addr == 5'h12 |=> reg_rdata == $past(port_status.part_link))
    else $error("partition link readback wrong");
  a_disable_wr: assert property (
    reg_write && reg_addr == 5'h15 && frame_latch_strobe_oe
      |=> {isolation_disable, partition_disable} == $past(reg_wdata))
    else $error("disable word not applied");
  a_enable_wr: assert property (
    reg_write && reg_addr == 5'h11 && frame_latch_strobe_oe
      |=> {8'h00, port_enable} == ($past(reg_wdata) & 16'h00FF))
    else $error("enable word not applied");

  c_strobe: cover property ($rose(frame_latch_strobe_out));
  c_iso: cover property (reg_read && reg_addr == 5'h14);
  c_leave: cover property ($fell(read_write_select) && frame_latch_strobe_oe);
endmodule

bind scsp_top scsp_checker u_chk (.*);

// *** verif/scsp_far_model.sv ***
`timescale 1ns/10ps
module scsp_far_model (
  // link clock and direction
  output logic shift_clock,
  output logic read_write_select,
  // resolved pin levels
  output wire logic port_scrambler_enable_in,
  output wire logic partition_detach_disable_in,
  output wire logic frame_latch_strobe_in,
  // block side of the pins
  input wire logic partition_link_status_out,
  input wire logic jabber_buffer_status_out,
  input wire logic port_cutoff_status_out,
  input wire logic port_scrambler_enable_out,
  input wire logic port_scrambler_enable_oe,
  input wire logic partition_detach_disable_out,
  input wire logic partition_detach_disable_oe,
  input wire logic frame_latch_strobe_out,
  input wire logic frame_latch_strobe_oe
);
  logic drv, m_en, m_dis, m_stb;

  // released lines settle to their pull levels
  assign port_scrambler_enable_in =
    port_scrambler_enable_oe ? port_scrambler_enable_out : (drv ? m_en : 1'h1);
  assign partition_detach_disable_in =
    partition_detach_disable_oe ? partition_detach_disable_out : (drv ? m_dis : 1'h0);
  assign frame_latch_strobe_in = frame_latch_strobe_oe ? frame_latch_strobe_out : m_stb;

  initial begin
    shift_clock = 0;
    read_write_select = 0;
    drv = 0;
    m_en = 0;
    m_dis = 0;
    m_stb = 0;
  end

  task pulse;
    shift_clock = 1;
    #80;
    shift_clock = 0;
    #80;
  endtask

  // direction moves off the clock edge
  task set_dir(input logic d);
    #1;
    read_write_select = d;
    #200;
  endtask

  task send_word(input logic [15:0] en, input logic [15:0] dis);
    m_stb = 1;
    #100;
    drv = 1;
    for (int i = 0; i < 16; i++) begin
      m_en = en[i];
      m_dis = dis[i];
      #80;
      pulse;
    end
    drv = 0;
    m_stb = 0;
    #200;
  endtask

  task read_frame(output logic [15:0] pl, jb, en, di, io, output logic ok);
    ok = 1;
    for (int i = 0; i < 19; i++) begin
      shift_clock = 1;
      if (i > 0 && i < 17) begin
        pl[i-1] = partition_link_status_out;
        jb[i-1] = jabber_buffer_status_out;
        en[i-1] = port_scrambler_enable_in;
        di[i-1] = partition_detach_disable_in;
        io[i-1] = port_cutoff_status_out;
        ok &= !frame_latch_strobe_in;
      end else if (i == 17) begin
        ok &= frame_latch_strobe_in && !partition_link_status_out;
      end else if (i == 18) begin
        ok &= !frame_latch_strobe_in && partition_link_status_out === pl[0];
      end
      #80;
      shift_clock = 0;
      #80;
    end
  endtask
endmodule

// *** verif/scsp_top_tb.sv ***
`timescale 1ns/10ps
module scsp_top_tb;
  import scsp_pkg::*;
  // *******
  // signals
  // *******
  localparam logic [15:0] EN_W = 16'hA53C;
  localparam logic [15:0] DIS_W = 16'h5AC3;
  localparam logic [15:0] EN_R = 16'h81E7;
  logic clock, rst_b, scrambler_bypass_select, reg_write, reg_read;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  scsp_status_t port_status;
  logic [7:0] port_enable, scrambler_active, partition_disable, isolation_disable;
  logic partition_link_status_out, jabber_buffer_status_out, port_cutoff_status_out;
  logic port_scrambler_enable_out, port_scrambler_enable_oe, partition_detach_disable_out;
  logic partition_detach_disable_oe, frame_latch_strobe_out, frame_latch_strobe_oe;
  logic mgmt_data_force_low, shift_clock, read_write_select, ok;
  wire port_scrambler_enable_in, partition_detach_disable_in, frame_latch_strobe_in;
  logic [15:0] pl, jb, en, di, io;
  int err_total, checks_done;

  scsp_top dut (.*);
  scsp_far_model far (.*);

  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end

  // *******
  // tasks
  // *******
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task rchk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge clock);
    reg_read <= 0;
    #1 chk(reg_rdata, exp);
  endtask

  task wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1;
    @(posedge clock);
    reg_write <= 0;
  endtask

  task do_reset;
    @(posedge clock);
    rst_b <= 0;
    repeat (4) @(posedge clock);
    rst_b <= 1;
    repeat (4) @(posedge clock);
  endtask

  task chk_reset;
    chk({8'h00, port_enable}, 16'h00FF);
    chk({8'h00, scrambler_active}, 16'h00FF);
    chk({isolation_disable, partition_disable}, 16'h0000);
    chk({15'h0000, mgmt_data_force_low}, {15'h0000, !read_write_select});
    rchk(5'h11, 16'hFFFF);
    rchk(5'h15, 16'h0000);
    rchk(5'h00, 16'h0000);
    rchk(5'h01, 16'h0000);
    rchk(5'h10, 16'h0000);
    rchk(5'h16, 16'h0000);
    rchk(5'h1F, 16'h0000);
    $display("test reset values done");
  endtask

  task end_sim;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    end_sim;
  end

  // *******
  // sequence
  // *******
  initial begin
    rst_b = 0;
    scrambler_bypass_select = 1;
    reg_write = 0;
    reg_read = 0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    port_status = {16'hC3A5, 16'h0F96, 8'h6B};
    err_total = 0;
    checks_done = 0;
    do_reset;
    chk_reset;
    far.send_word(EN_W, DIS_W);
    repeat (8) @(posedge clock);
    chk({8'h00, port_enable}, 16'h003C);
    chk({8'h00, scrambler_active}, 16'h00A5);
    chk({isolation_disable, partition_disable}, DIS_W);
    wreg(5'h15, 16'hFFFF);
    rchk(5'h15, DIS_W);
    rchk(5'h11, EN_W);
    @(posedge clock) scrambler_bypass_select <= 0;
    repeat (6) @(posedge clock);
    chk({8'h00, scrambler_active}, 16'h0000);
    @(posedge clock) scrambler_bypass_select <= 1;
    $display("test serial write done");
    far.set_dir(1);
    chk({15'h0000, mgmt_data_force_low}, 16'h0000);
    wreg(5'h11, EN_R);
    wreg(5'h15, DIS_W);
    wreg(5'h12, 16'h0000);
    rchk(5'h12, 16'hC3A5);
    rchk(5'h13, 16'h0F96);
    rchk(5'h14, 16'h006B);
    far.read_frame(pl, jb, en, di, io, ok);
    chk(pl, 16'hC3A5);
    chk(jb, 16'h0F96);
    chk(en, EN_R);
    chk(di, DIS_W);
    chk({8'h00, io[7:0]}, 16'h006B);
    chk({15'h0000, ok}, 16'h0001);
    $display("test read frame done");
    repeat (5) far.pulse;
    far.set_dir(0);
    chk({12'h000, partition_link_status_out, jabber_buffer_status_out,
      port_cutoff_status_out, frame_latch_strobe_out}, 16'h0000);
    far.set_dir(1);
    far.read_frame(pl, jb, en, di, io, ok);
    chk(pl, 16'hC3A5);
    chk({15'h0000, ok}, 16'h0001);
    $display("test abort done");
    do_reset;
    chk_reset;
    $display("test mid reset done");
    end_sim;
  end
endmodule
